// >>> hw/pbi_bus_if.sv
// shared bus wires with the level of each line worked out from the drivers
`timescale 1ns/1ps
interface pbi_bus_if;
  logic [31:0] m_ad_o;
  logic        m_ad_oe;
  logic [3:0]  m_cbe_o;
  logic        m_par_o;
  logic        m_par_oe;
  logic        m_frame_o;
  logic        m_irdy_o;
  logic        m_ctl_oe;
  logic        m_lock_o;
  logic        m_lock_oe;
  logic        m_idsel;
  logic [31:0] t_ad_o;
  logic        t_ad_oe;
  logic        t_par_o;
  logic        t_par_oe;
  logic        t_trdy_o;
  logic        t_stop_o;
  logic        t_devsel_o;
  logic        t_ctl_oe;
  logic        t_perr_o;
  logic        t_perr_oe;
  logic        t_serr_oe;
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic        par;
  logic        frame_n;
  logic        irdy_n;
  logic        lock_n;
  logic        trdy_n;
  logic        stop_n;
  logic        devsel_n;
  logic        perr_n;
  logic        serr_n;
  logic        idsel;

  // undriven control lines rest at their pulled-up idle level; undriven ad and par rest at zero
  assign ad       = t_ad_oe ? t_ad_o : (m_ad_oe ? m_ad_o : '0);
  assign cbe      = m_ctl_oe ? m_cbe_o : 4'hf;
  assign par      = t_par_oe ? t_par_o : (m_par_oe ? m_par_o : 1'b0);
  assign frame_n  = m_ctl_oe ? m_frame_o : 1'b1;
  assign irdy_n   = m_ctl_oe ? m_irdy_o : 1'b1;
  assign lock_n   = m_lock_oe ? m_lock_o : 1'b1;
  assign trdy_n   = t_ctl_oe ? t_trdy_o : 1'b1;
  assign stop_n   = t_ctl_oe ? t_stop_o : 1'b1;
  assign devsel_n = t_ctl_oe ? t_devsel_o : 1'b1;
  assign perr_n   = t_perr_oe ? t_perr_o : 1'b1;
  assign serr_n   = ~t_serr_oe;
  assign idsel    = m_idsel;

  modport dev (
    input  ad, cbe, par, frame_n, irdy_n, lock_n, idsel,
    output t_ad_o, t_ad_oe, t_par_o, t_par_oe, t_trdy_o, t_stop_o, t_devsel_o,
    output t_ctl_oe, t_perr_o, t_perr_oe, t_serr_oe
  );
  modport host (
    input  ad, cbe, par, trdy_n, stop_n, devsel_n, perr_n, serr_n,
    output m_ad_o, m_ad_oe, m_cbe_o, m_par_o, m_par_oe, m_frame_o, m_irdy_o,
    output m_ctl_oe, m_lock_o, m_lock_oe, m_idsel
  );
endinterface

// >>> hw/pbi_dev_end.sv
// target end: claims memory and configuration accesses to a small word store
`timescale 1ns/1ps
// What this block does
// - shared 32 lines carry address then data
// - address phase cbe lines give command
// - data phase cbe lines are byte enables
// - frame low runs transfer, high marks last
// - initiator ready plus target ready completes phase
// - target ready paired with initiator ready
// - target stop makes master end transaction
// - lock keeps resource for one master only
// - configuration cycles answered only with idsel
// - claim own address by driving devsel
// - master watches devsel for a claim
// - write data parity error drives perr low
// - parity is even over ad and cbe
// - address parity error pulses system error
// - everything sampled on rising clock edge
// - reset clears state and floats all bus outputs
module pbi_dev_end #(
  parameter int          DEPTH = 16,
  parameter logic [31:0] BASE  = pbi_pkg::DEV_BASE_RST
) (
  // clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     RESETN,
  // bus
  pbi_bus_if.dev                        BUS,
  // user side
  output wire logic                     WR_STB,
  output wire logic [$clog2(DEPTH)-1:0] WR_INDEX,
  output wire logic [31:0]              WR_DATA,
  output wire logic [3:0]               WR_BE,
  output wire logic                     ADDR_PERR,
  output wire logic                     LOCKED
);
  localparam int IW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 64 || (1 << IW) != DEPTH)
  begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 64");
  end

  typedef enum logic [2:0] {T_IDLE, T_DATA, T_HOLD, T_TURN} pbi_tst_t;

  typedef struct packed {
    pbi_tst_t                 st;
    logic                     write;
    logic [IW-1:0]            idx;
    logic                     frame_q;
    logic                     par_q;
    logic                     apar_chk;
    logic                     dpar_chk;
    logic                     locked;
    logic [DEPTH-1:0][31:0]   mem;
    logic [31:0]              ad_o;
    logic                     ad_oe;
    logic                     par_o;
    logic                     par_oe;
    logic                     trdy_n;
    logic                     stop_n;
    logic                     devsel_n;
    logic                     ctl_oe;
    logic                     perr_n;
    logic                     perr_oe;
    logic                     serr_oe;
    logic                     wr_stb;
    logic [IW-1:0]            wr_idx;
    logic [31:0]              wr_data;
    logic [3:0]               wr_be;
    logic                     aperr;
  } pbi_dst_t;

  pbi_dst_t s_ff;
  pbi_dst_t nxt_s;
  logic     bus_par;
  logic     addr_phase;
  logic     hit_mem;
  logic     hit_cfg;
  logic     is_write;
  logic     xfer;

  pbi_parity #(
    .W (36)
  ) u_par (
    .data ({BUS.ad, BUS.cbe}),
    .par  (bus_par)
  );

  // a falling frame with the bus idle is an address phase
  assign addr_phase = (s_ff.st == T_IDLE) && !BUS.frame_n && s_ff.frame_q;
  assign hit_mem    = (BUS.cbe == pbi_pkg::CMD_MEM_RD || BUS.cbe == pbi_pkg::CMD_MEM_WR) &&
                      (BUS.ad[31:IW+2] == BASE[31:IW+2]);
  assign hit_cfg    = BUS.idsel && BUS.ad[1:0] == 2'b00 &&
                      (BUS.cbe == pbi_pkg::CMD_CFG_RD || BUS.cbe == pbi_pkg::CMD_CFG_WR);
  assign is_write   = (BUS.cbe == pbi_pkg::CMD_MEM_WR) || (BUS.cbe == pbi_pkg::CMD_CFG_WR);
  assign xfer       = !BUS.irdy_n && !s_ff.trdy_n;

  always_comb
  begin
    nxt_s          = s_ff;
    nxt_s.frame_q  = BUS.frame_n;
    nxt_s.par_q    = bus_par;
    nxt_s.apar_chk = 1'b0;
    nxt_s.dpar_chk = 1'b0;
    nxt_s.serr_oe  = 1'b0;
    nxt_s.aperr    = 1'b0;
    nxt_s.wr_stb   = 1'b0;
    nxt_s.perr_n   = 1'b1;
    // parity driven one clock after the data it covers
    nxt_s.par_o    = bus_par;
    nxt_s.par_oe   = s_ff.ad_oe;
    // address parity is checked one clock after the address phase
    if (s_ff.apar_chk && BUS.par != s_ff.par_q)
    begin
      nxt_s.serr_oe = 1'b1;
      nxt_s.aperr   = 1'b1;
    end
    if (s_ff.dpar_chk && BUS.par != s_ff.par_q)
    begin
      nxt_s.perr_n = 1'b0;
    end
    nxt_s.perr_oe = s_ff.dpar_chk ||
                    (s_ff.write && (s_ff.st == T_DATA || s_ff.st == T_HOLD));
    unique case (s_ff.st)
      T_IDLE:
      begin
        nxt_s.ctl_oe = 1'b0;
        nxt_s.ad_oe  = 1'b0;
        if (BUS.frame_n && BUS.lock_n)
        begin
          nxt_s.locked = 1'b0;
        end
        if (addr_phase)
        begin
          nxt_s.apar_chk = 1'b1;
          if (hit_mem || hit_cfg)
          begin
            nxt_s.write    = is_write;
            nxt_s.idx      = BUS.ad[IW+1:2];
            nxt_s.ctl_oe   = 1'b1;
            nxt_s.devsel_n = 1'b0;
            if (s_ff.locked && !BUS.lock_n)
            begin
              // another master while locked: claim and retry without data
              nxt_s.stop_n = 1'b0;
              nxt_s.trdy_n = 1'b1;
              nxt_s.st     = T_HOLD;
            end
            else
            begin
              // reads keep ready off for one turnaround clock
              nxt_s.trdy_n = !is_write;
              nxt_s.ad_oe  = !is_write;
              nxt_s.ad_o   = s_ff.mem[BUS.ad[IW+1:2]];
              nxt_s.st     = T_DATA;
            end
          end
        end
      end
      T_DATA:
      begin
        nxt_s.trdy_n = 1'b0;
        if (xfer)
        begin
          if (s_ff.write)
          begin
            for (int b = 0; b < 4; b++)
            begin
              if (!BUS.cbe[b])
              begin
                nxt_s.mem[s_ff.idx][8*b +: 8] = BUS.ad[8*b +: 8];
              end
            end
            nxt_s.wr_stb   = 1'b1;
            nxt_s.wr_idx   = s_ff.idx;
            nxt_s.wr_data  = BUS.ad;
            nxt_s.wr_be    = ~BUS.cbe;
            nxt_s.dpar_chk = 1'b1;
          end
          else
          begin
            nxt_s.ad_o = s_ff.mem[IW'(s_ff.idx + 1'b1)];
          end
          if (!BUS.lock_n)
          begin
            nxt_s.locked = 1'b1;
          end
          nxt_s.idx = IW'(s_ff.idx + 1'b1);
          if (BUS.frame_n)
          begin
            nxt_s.trdy_n   = 1'b1;
            nxt_s.devsel_n = 1'b1;
            nxt_s.ad_oe    = 1'b0;
            nxt_s.st       = T_TURN;
          end
          else if (s_ff.idx == IW'(DEPTH - 1))
          begin
            // end of the store: disconnect before the next word
            nxt_s.trdy_n = 1'b1;
            nxt_s.stop_n = 1'b0;
            nxt_s.ad_oe  = 1'b0;
            nxt_s.st     = T_HOLD;
          end
        end
      end
      T_HOLD:
      begin
        nxt_s.ad_oe = 1'b0;
        if (BUS.frame_n)
        begin
          nxt_s.stop_n   = 1'b1;
          nxt_s.devsel_n = 1'b1;
          nxt_s.st       = T_TURN;
        end
      end
      T_TURN:
      begin
        // lines were driven high for one clock, now released
        nxt_s.ctl_oe = 1'b0;
        nxt_s.st     = T_IDLE;
      end
      default:
      begin
        nxt_s.st = T_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      s_ff          <= '0;
      s_ff.st       <= T_IDLE;
      s_ff.frame_q  <= 1'b1;
      s_ff.trdy_n   <= 1'b1;
      s_ff.stop_n   <= 1'b1;
      s_ff.devsel_n <= 1'b1;
      s_ff.perr_n   <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign BUS.t_ad_o     = s_ff.ad_o;
  assign BUS.t_ad_oe    = s_ff.ad_oe;
  assign BUS.t_par_o    = s_ff.par_o;
  assign BUS.t_par_oe   = s_ff.par_oe;
  assign BUS.t_trdy_o   = s_ff.trdy_n;
  assign BUS.t_stop_o   = s_ff.stop_n;
  assign BUS.t_devsel_o = s_ff.devsel_n;
  assign BUS.t_ctl_oe   = s_ff.ctl_oe;
  assign BUS.t_perr_o   = s_ff.perr_n;
  assign BUS.t_perr_oe  = s_ff.perr_oe;
  assign BUS.t_serr_oe  = s_ff.serr_oe;
  assign WR_STB         = s_ff.wr_stb;
  assign WR_INDEX       = s_ff.wr_idx;
  assign WR_DATA        = s_ff.wr_data;
  assign WR_BE          = s_ff.wr_be;
  assign ADDR_PERR      = s_ff.aperr;
  assign LOCKED         = s_ff.locked;
endmodule

// >>> hw/pbi_host_end.sv
// master end: runs one single-word transaction per user request
`timescale 1ns/1ps
module pbi_host_end (
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                RESETN,
  // bus
  pbi_bus_if.host                  BUS,
  // request
  input  wire logic                REQ,
  input  wire logic [3:0]          REQ_CMD,
  input  wire logic [31:0]         REQ_ADDR,
  input  wire logic [31:0]         REQ_DATA,
  input  wire logic [3:0]          REQ_BE,
  input  wire logic                REQ_LOCK,
  // answer
  output wire logic                BUSY,
  output wire logic                DONE,
  output wire logic [31:0]         RD_DATA,
  output wire pbi_pkg::pbi_status_t STATUS
);
  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_DATA, H_TURN} pbi_hst_t;

  typedef struct packed {
    pbi_hst_t             st;
    logic                 write;
    logic                 lock_req;
    logic                 lock_own;
    logic [31:0]          data;
    logic [3:0]           be;
    logic [2:0]           wait_cnt;
    logic [31:0]          ad_o;
    logic                 ad_oe;
    logic [3:0]           cbe_o;
    logic                 par_o;
    logic                 par_oe;
    logic                 frame_n;
    logic                 irdy_n;
    logic                 ctl_oe;
    logic                 idsel;
    logic                 busy;
    logic                 done;
    logic [31:0]          rd_data;
    pbi_pkg::pbi_status_t status;
  } pbi_hs_t;

  pbi_hs_t s_ff;
  pbi_hs_t nxt_s;
  logic    bus_par;
  logic    is_cfg;

  pbi_parity #(
    .W (36)
  ) u_par (
    .data ({BUS.ad, BUS.cbe}),
    .par  (bus_par)
  );

  assign is_cfg = (REQ_CMD == pbi_pkg::CMD_CFG_RD) || (REQ_CMD == pbi_pkg::CMD_CFG_WR);

  always_comb
  begin
    nxt_s        = s_ff;
    nxt_s.done   = 1'b0;
    nxt_s.idsel  = 1'b0;
    nxt_s.par_o  = bus_par;
    nxt_s.par_oe = s_ff.ad_oe;
    unique case (s_ff.st)
      H_IDLE:
      begin
        nxt_s.ctl_oe = 1'b0;
        nxt_s.ad_oe  = 1'b0;
        if (REQ && BUS.devsel_n && BUS.trdy_n)
        begin
          nxt_s.write    = (REQ_CMD == pbi_pkg::CMD_MEM_WR) ||
                           (REQ_CMD == pbi_pkg::CMD_CFG_WR);
          nxt_s.lock_req = REQ_LOCK;
          nxt_s.data     = REQ_DATA;
          nxt_s.be       = REQ_BE;
          nxt_s.ad_o     = REQ_ADDR;
          nxt_s.ad_oe    = 1'b1;
          nxt_s.cbe_o    = REQ_CMD;
          nxt_s.idsel    = is_cfg;
          nxt_s.frame_n  = 1'b0;
          nxt_s.irdy_n   = 1'b1;
          nxt_s.ctl_oe   = 1'b1;
          nxt_s.busy     = 1'b1;
          nxt_s.st       = H_ADDR;
        end
      end
      H_ADDR:
      begin
        // one data phase: frame rises with the first ready
        nxt_s.frame_n  = 1'b1;
        nxt_s.irdy_n   = 1'b0;
        nxt_s.cbe_o    = s_ff.be;
        nxt_s.ad_o     = s_ff.data;
        nxt_s.ad_oe    = s_ff.write;
        nxt_s.wait_cnt = 3'h1;
        nxt_s.st       = H_DATA;
      end
      H_DATA:
      begin
        if (BUS.devsel_n)
        begin
          nxt_s.wait_cnt = 3'(s_ff.wait_cnt + 1'b1);
        end
        if (!BUS.trdy_n)
        begin
          nxt_s.rd_data  = BUS.ad;
          nxt_s.status   = pbi_pkg::PBI_OK;
          nxt_s.lock_own = s_ff.lock_req;
          nxt_s.st       = H_TURN;
        end
        else if (!BUS.stop_n)
        begin
          nxt_s.status = pbi_pkg::PBI_RETRY;
          nxt_s.st     = H_TURN;
        end
        else if (BUS.devsel_n && s_ff.wait_cnt == 3'(pbi_pkg::DEVSEL_WAIT_CYC))
        begin
          nxt_s.status = pbi_pkg::PBI_ABORT;
          nxt_s.st     = H_TURN;
        end
        if (nxt_s.st == H_TURN)
        begin
          nxt_s.irdy_n = 1'b1;
          nxt_s.ad_oe  = 1'b0;
          nxt_s.done   = 1'b1;
          nxt_s.busy   = 1'b0;
          if (!s_ff.lock_req)
          begin
            nxt_s.lock_own = 1'b0;
          end
        end
      end
      H_TURN:
      begin
        nxt_s.ctl_oe = 1'b0;
        nxt_s.st     = H_IDLE;
      end
      default:
      begin
        nxt_s.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      s_ff         <= '0;
      s_ff.st      <= H_IDLE;
      s_ff.frame_n <= 1'b1;
      s_ff.irdy_n  <= 1'b1;
      s_ff.cbe_o   <= 4'hf;
      s_ff.status  <= pbi_pkg::PBI_OK;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // lock is released in address phases so the owner is told apart
  assign BUS.m_lock_o  = !(s_ff.st != H_ADDR &&
                           (s_ff.lock_own || (s_ff.st == H_DATA && s_ff.lock_req)));
  assign BUS.m_lock_oe = s_ff.lock_own || s_ff.lock_req && s_ff.st != H_IDLE;
  assign BUS.m_ad_o    = s_ff.ad_o;
  assign BUS.m_ad_oe   = s_ff.ad_oe;
  assign BUS.m_cbe_o   = s_ff.cbe_o;
  assign BUS.m_par_o   = s_ff.par_o;
  assign BUS.m_par_oe  = s_ff.par_oe;
  assign BUS.m_frame_o = s_ff.frame_n;
  assign BUS.m_irdy_o  = s_ff.irdy_n;
  assign BUS.m_ctl_oe  = s_ff.ctl_oe;
  assign BUS.m_idsel   = s_ff.idsel;
  assign BUSY          = s_ff.busy;
  assign DONE          = s_ff.done;
  assign RD_DATA       = s_ff.rd_data;
  assign STATUS        = s_ff.status;
endmodule

// >>> hw/pbi_parity.sv
// even parity bit over a data word
`timescale 1ns/1ps
module pbi_parity #(
  parameter int W = 36
) (
  input  wire logic [W-1:0] data,
  output wire logic         par
);
  assign par = ^data;
endmodule

// >>> hw/pbi_pkg.sv
// shared constants and types of the bus interface ends
package pbi_pkg;
  localparam int          AD_W            = 32;
  localparam int          CBE_W           = 4;
  localparam logic [3:0]  CMD_MEM_RD      = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR      = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD      = 4'ha;
  localparam logic [3:0]  CMD_CFG_WR      = 4'hb;
  localparam logic [3:0]  BE_ALL          = 4'h0;
  // clocks after the address phase that the master waits for a claim
  localparam int          DEVSEL_WAIT_CYC = 5;
  localparam logic [31:0] DEV_BASE_RST    = 32'h0001_0000;
  localparam logic [31:0] AD_RST          = 32'h0000_0000;
  typedef enum logic [1:0] {PBI_OK, PBI_ABORT, PBI_RETRY} pbi_status_t;
endpackage

// >>> verification/pbi_checker.sv
// bus protocol checks on the link between the two ends
`timescale 1ns/1ps
module pbi_checker #(
  parameter int          DEPTH = 16,
  parameter logic [31:0] BASE  = pbi_pkg::DEV_BASE_RST
) (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RESETN,
  // resolved lines
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic        par,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        trdy_n,
  input wire logic        devsel_n,
  input wire logic        perr_n,
  input wire logic        serr_n,
  input wire logic        idsel,
  // drive enables
  input wire logic        t_ad_oe,
  input wire logic        t_ctl_oe,
  input wire logic        t_par_oe,
  input wire logic        m_ctl_oe,
  input wire logic        m_par_oe
);
  localparam int IW = $clog2(DEPTH);
  wire logic     hit = ad[31:IW+2] == BASE[31:IW+2];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence s_mem_addr;
    $fell(frame_n) && hit && cbe[3:1] == 3'h3;
  endsequence
  sequence s_turn;
    trdy_n && devsel_n && t_ctl_oe ##1 !t_ctl_oe;
  endsequence
  property p_reset_quiet;
    $rose(RESETN) |-> !t_ctl_oe && !t_ad_oe && !m_ctl_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("bus driven right after reset");
  property p_claim_mem;
    s_mem_addr |=> !devsel_n && t_ctl_oe;
  endproperty
  a_claim_mem: assert property (p_claim_mem)
    else $error("memory hit not claimed");
  property p_claim_cfg;
    $fell(frame_n) && idsel && ad[1:0] == 2'h0 && cbe[3:1] == 3'h5 |=> !devsel_n;
  endproperty
  a_claim_cfg: assert property (p_claim_cfg)
    else $error("selected config access not claimed");
  property p_read_wait;
    (s_mem_addr and !cbe[0]) |=> trdy_n && t_ad_oe ##1 !trdy_n;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data phase timing wrong");
  property p_release;
    !irdy_n && !trdy_n && frame_n |=> s_turn;
  endproperty
  a_release: assert property (p_release)
    else $error("target did not end after final transfer");
  property p_parity;
    t_par_oe || m_par_oe |-> par == (^$past(ad) ^ ^$past(cbe));
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity line not even");
  property p_addr_serr;
    $fell(frame_n) |=> ##1 serr_n == ($past(par) == (^$past(ad, 2) ^ ^$past(cbe, 2)));
  endproperty
  a_addr_serr: assert property (p_addr_serr)
    else $error("system error does not follow address parity");
  property p_write_perr;
    !irdy_n && !trdy_n && !t_ad_oe |=> ##1
      perr_n == ($past(par) == (^$past(ad, 2) ^ ^$past(cbe, 2)));
  endproperty
  a_write_perr: assert property (p_write_perr)
    else $error("parity error line does not follow write data parity");
  property p_be_hold;
    !irdy_n && trdy_n && !devsel_n |=> $stable(cbe);
  endproperty
  a_be_hold: assert property (p_be_hold)
    else $error("byte enables changed inside a data phase");
endmodule

// >>> verification/tb_top.sv
// self-checking bench: both ends joined, plus a fault driver on a second bus
`timescale 1ns/1ps
module tb_top;
  logic                 mclk;
  logic                 resetn;
  logic                 req;
  logic [3:0]           req_cmd;
  logic [31:0]          req_addr;
  logic [31:0]          req_data;
  logic [3:0]           req_be;
  logic                 req_lock;
  logic                 busy;
  logic                 done;
  logic [31:0]          rd_data;
  pbi_pkg::pbi_status_t status;
  logic                 wstb;
  logic [3:0]           widx;
  logic [31:0]          wdata;
  logic [3:0]           wbe;
  logic                 locked;
  logic                 b_aperr;
  logic                 b_locked;
  logic [31:0]          mem [16];
  int                   fails;
  int                   checks_done;
  int                   wcnt;
  int                   acnt;
  int                   cyc;

  pbi_bus_if ba ();
  pbi_bus_if bb ();
  pbi_dev_end #(.DEPTH(16), .BASE(pbi_pkg::DEV_BASE_RST)) pbi_dev_end_i (
    .MCLK(mclk), .RESETN(resetn), .BUS(ba), .WR_STB(wstb), .WR_INDEX(widx),
    .WR_DATA(wdata), .WR_BE(wbe), .ADDR_PERR(), .LOCKED(locked));
  pbi_host_end pbi_host_end_i (
    .MCLK(mclk), .RESETN(resetn), .BUS(ba), .REQ(req), .REQ_CMD(req_cmd),
    .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_BE(req_be), .REQ_LOCK(req_lock),
    .BUSY(busy), .DONE(done), .RD_DATA(rd_data), .STATUS(status));
  pbi_checker #(.DEPTH(16), .BASE(pbi_pkg::DEV_BASE_RST)) pbi_checker_i (
    .MCLK(mclk), .RESETN(resetn), .ad(ba.ad), .cbe(ba.cbe), .par(ba.par),
    .frame_n(ba.frame_n), .irdy_n(ba.irdy_n), .trdy_n(ba.trdy_n), .devsel_n(ba.devsel_n),
    .perr_n(ba.perr_n), .serr_n(ba.serr_n), .idsel(ba.idsel), .t_ad_oe(ba.t_ad_oe),
    .t_ctl_oe(ba.t_ctl_oe), .t_par_oe(ba.t_par_oe), .m_ctl_oe(ba.m_ctl_oe),
    .m_par_oe(ba.m_par_oe));
  // second device end, driven by the bench acting as a faulty master
  pbi_dev_end #(.DEPTH(16), .BASE(pbi_pkg::DEV_BASE_RST)) pbi_dev_end_b_i (
    .MCLK(mclk), .RESETN(resetn), .BUS(bb), .WR_STB(), .WR_INDEX(), .WR_DATA(),
    .WR_BE(), .ADDR_PERR(b_aperr), .LOCKED(b_locked));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (wstb === 1'b1)
      wcnt++;
    if (b_aperr === 1'b1)
      acnt++;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [31:0] addr_of(input logic cfg, input logic [3:0] idx);
    addr_of = cfg ? {26'h0, idx, 2'h0} : {pbi_pkg::DEV_BASE_RST[31:6], idx, 2'h0};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++)
      if (!be[b])
        merge[8*b +: 8] = nw[8*b +: 8];
  endfunction

  // one host request, held until taken, then wait for its completion
  task automatic hreq(input logic [3:0] cmd, input logic [31:0] adr, input logic [31:0] d,
                      input logic [3:0] be, input logic lk, output logic [31:0] rd);
    int n;
    n        = 0;
    req_cmd  = cmd;
    req_addr = adr;
    req_data = d;
    req_be   = be;
    req_lock = lk;
    req      = 1'b1;
    do cycles(1); while (busy !== 1'b1 && ++n < 20);
    req = 1'b0;
    do cycles(1); while (done !== 1'b1 && ++n < 40);
    chk("completion", 1'b1, done);
    rd = rd_data;
    cycles(2);
  endtask

  // one write on the second bus; f = transfer, stop, claim, system error, parity error
  task automatic bxfer(input logic [3:0] cmd, input logic [31:0] adr, input logic sel,
                       input logic la, input logic ld, input logic ap, input logic dp,
                       output logic [4:0] f);
    logic [31:0] d;
    int          ph;
    d            = $urandom;
    f            = 5'h0;
    ph           = 0;
    bb.m_ad_o    = adr;
    bb.m_cbe_o   = cmd;
    bb.m_idsel   = sel;
    bb.m_lock_o  = la;
    bb.m_frame_o = 1'b0;
    bb.m_ctl_oe  = 1'b1;
    bb.m_ad_oe   = 1'b1;
    cycles(1);
    bb.m_par_o   = ^{adr, cmd} ^ ap;
    bb.m_par_oe  = 1'b1;
    bb.m_frame_o = 1'b1;
    bb.m_irdy_o  = 1'b0;
    bb.m_ad_o    = d;
    bb.m_cbe_o   = 4'h0;
    bb.m_idsel   = 1'b0;
    bb.m_lock_o  = ld;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge mclk);
      f = f | {!bb.trdy_n && !bb.irdy_n, !bb.stop_n, !bb.devsel_n, !bb.serr_n, !bb.perr_n};
      #1;
      if (ph == 1)
      begin
        bb.m_ctl_oe = 1'b0;
        bb.m_par_oe = 1'b0;
      end
      if (ph > 0)
        ph++;
      else if (f[4] || f[3] || k == 4)
      begin
        bb.m_irdy_o = 1'b1;
        bb.m_ad_oe  = 1'b0;
        bb.m_par_o  = ^{d, 4'h0} ^ dp;
        ph          = 1;
      end
    end
  endtask

  initial
  begin
    logic [3:0]  idx;
    logic [3:0]  be;
    logic [31:0] d;
    logic [31:0] rd;
    logic        cfg;
    logic [4:0]  f;
    int          ew;
    ew = 0;
    {resetn, req, req_cmd, req_addr, req_data, req_be, req_lock} = '0;
    {bb.m_ctl_oe, bb.m_ad_oe, bb.m_par_oe, bb.m_idsel, bb.m_ad_o, bb.m_par_o} = '0;
    {bb.m_frame_o, bb.m_irdy_o, bb.m_lock_o, bb.m_lock_oe, bb.m_cbe_o} = '1;
    foreach (mem[i])
      mem[i] = 32'h0;
    void'($urandom(32'hd946da0f));
    cycles(6);
    resetn = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      idx = (i == 0) ? 4'hf : 4'($urandom_range(15));
      be  = (i < 2) ? {4{i[0]}} : 4'($urandom);
      d   = $urandom;
      cfg = 1'($urandom);
      hreq(cfg ? pbi_pkg::CMD_CFG_WR : pbi_pkg::CMD_MEM_WR, addr_of(cfg, idx), d, be, 1'b0, rd);
      mem[idx] = merge(mem[idx], d, be);
      ew++;
      chk("write status", pbi_pkg::PBI_OK, status);
      chk("write strobes", ew, wcnt);
      chk("write index", idx, widx);
      chk("write data", d, wdata);
      chk("write enables", 4'(~be), wbe);
      cfg = 1'($urandom);
      hreq(cfg ? pbi_pkg::CMD_CFG_RD : pbi_pkg::CMD_MEM_RD, addr_of(cfg, idx), d, 4'h0, 1'b0, rd);
      chk("read data", mem[idx], rd);
    end
    $display("test random traffic done");
    hreq(pbi_pkg::CMD_MEM_RD, ~pbi_pkg::DEV_BASE_RST, 32'h0, 4'h0, 1'b0, rd);
    chk("miss status", pbi_pkg::PBI_ABORT, status);
    hreq(pbi_pkg::CMD_CFG_WR, 32'h0000_0005, 32'h0, 4'h0, 1'b0, rd);
    chk("config offset status", pbi_pkg::PBI_ABORT, status);
    chk("strobes after misses", ew, wcnt);
    $display("test misses done");
    hreq(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h3), 32'h0, 4'hf, 1'b1, rd);
    chk("lock taken", 1'b1, locked);
    hreq(pbi_pkg::CMD_MEM_RD, addr_of(1'b0, 4'h3), 32'h0, 4'h0, 1'b0, rd);
    chk("locked read data", mem[3], rd);
    chk("locked read status", pbi_pkg::PBI_OK, status);
    cycles(3);
    chk("lock freed", 1'b0, locked);
    $display("test host lock done");
    bxfer(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h1), 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, f);
    chk("clean write flags", 5'h14, f);
    bxfer(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h2), 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, f);
    chk("address parity flags", 5'h16, f);
    chk("address parity pulses", 1, acnt);
    bxfer(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h4), 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, f);
    chk("data parity flags", 5'h15, f);
    bxfer(pbi_pkg::CMD_CFG_WR, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, f);
    chk("unselected config flags", 5'h00, f);
    bxfer(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h5), 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, f);
    chk("locking write flags", 5'h14, f);
    chk("second end locked", 1'b1, b_locked);
    bxfer(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h6), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, f);
    chk("foreign lock flags", 5'h0c, f);
    bxfer(pbi_pkg::CMD_MEM_WR, addr_of(1'b0, 4'h7), 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, f);
    chk("owner write flags", 5'h14, f);
    cycles(3);
    chk("second end unlocked", 1'b0, b_locked);
    $display("test fault driver done");
    test_done();
  end
endmodule
